//--- design/ascs_baud.v
// baud rate generator: prescaler and reload counter giving sample ticks
`default_nettype none
`include "ascs_defs.vh"

module ascs_baud #(
  parameter RW = 16
) (
  input  wire          clk,
  input  wire          rst_b,
  input  wire          ce,
  input  wire          baud_prescale_select,
  input  wire [RW-1:0] reload,
  output reg           tick
);

  reg  [1:0]    pre;
  reg  [RW-1:0] cnt;
  wire [1:0]    pre_last;
  wire          pre_end;

  assign pre_last = baud_prescale_select ? `ASCS_PRE_DIV1 - 2'h1 : `ASCS_PRE_DIV0 - 2'h1;
  assign pre_end  = (pre >= pre_last);

  // tick rate is clk / (div * (reload + 1)), sixteen ticks per bit
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      pre  <= 2'h0;
      cnt  <= {RW{1'b0}};
      tick <= 1'b0;
    end
    else if (ce)
    begin
      tick <= 1'b0;
      if (pre_end)
      begin
        pre <= 2'h0;
        if (cnt >= reload)
        begin
          cnt  <= {RW{1'b0}};
          tick <= 1'b1;
        end
        else
          cnt <= cnt + {{(RW-1){1'b0}}, 1'b1};
      end
      else
        pre <= pre + 2'h1;
    end
  end

endmodule
`default_nettype wire

//--- design/ascs_channel.v
// asynchronous/synchronous serial channel: transmitter, receiver, errors
// Notes on behaviour
// R01: bit timing comes from an own baud generator fed by the clock and a reload value.
// R02: separate request pulses signal transmit done, receive done and receive error.
// R03: async characters have a start bit, 8 or 9 data bits and one or two stop bits.
// R04: the wake-up mode sends 8 data bits plus a wake bit marking address characters.
// R05: sync mode shifts 8-bit bytes against a shift clock the channel drives itself.
// R06: every mode shifts the least significant bit first, on both ends.
// R07: loopback feeds the transmitted stream straight back into the receiver.
// R08: with parity enabled in 9-bit mode the transmitter adds and the receiver checks a parity bit as the ninth bit.
// R09: with framing check enabled a missing stop bit flags a framing error.
// R10: with overrun check enabled a character completing into a full buffer flags overrun.
// R11: at a 50 MHz clock and reload zero the rate is 1562500 or 1041666 baud.
// R12: rate is clock over 32*(reload+1), or over 48*(reload+1) with prescale select set.
// R13: each detected error sets a flag held until cleared and raises the error request.
`default_nettype none
`include "ascs_defs.vh"

module ascs_channel #(
  parameter RW = 16
) (
  input  wire          clk,
  input  wire          rst_b,
  input  wire          ce,
  input  wire [1:0]    mode,
  input  wire          stop2,
  input  wire          parity_en,
  input  wire          parity_odd,
  input  wire          frame_chk_en,
  input  wire          ovr_chk_en,
  input  wire          loopback,
  input  wire          rcv_en,
  input  wire          baud_prescale_select,
  input  wire [RW-1:0] reload,
  input  wire [8:0]    tx_data,
  input  wire          tx_load,
  input  wire          rx_read,
  input  wire [2:0]    err_clr,
  output reg           tx_busy,
  output reg  [8:0]    rx_data,
  output reg           rx_full,
  output reg  [2:0]    err_flags,
  output reg           tx_irq,
  output reg           rx_irq,
  output reg           err_irq,
  output reg           txd_out,
  input  wire          rxd_in,
  output reg           rxd_out,
  output reg           rxd_oe
);

  wire tick;
  wire sync_mode;
  wire nine;
  wire par_calc;
  wire bit9;
  wire tx_line;
  wire rx_line;
  wire sclk;

  reg  [`ASCS_FRAME_W-1:0] txsr;
  reg  [3:0]               tx_cnt;
  reg  [3:0]               tx_bits;
  reg                      tx_sync;

  reg  [1:0]               rx_state;
  reg  [3:0]               rx_cnt;
  reg  [3:0]               rx_bits;
  reg  [8:0]               rxsr;
  reg                      rx_nine;
  reg                      rx_stop2;
  reg                      frm_bad;
  reg                      rx_prev;

  reg  [2:0]               next_err;
  reg                      next_store;
  reg  [8:0]               next_data;

  // rate set by prescale select and reload R11
  ascs_baud #(
    .RW (RW)
  ) u_baud (
    .clk                  (clk),
    .rst_b                (rst_b),
    .ce                   (ce),
    .baud_prescale_select (baud_prescale_select),
    .reload               (reload),
    .tick                 (tick)
  ); // R01 R12

  assign sync_mode = (mode == `ASCS_MODE_SYNC);
  assign nine      = (mode == `ASCS_MODE_A9) || (mode == `ASCS_MODE_WAKE);
  assign par_calc  = parity_odd ? ~^tx_data[7:0] : ^tx_data[7:0];
  // ninth bit: parity in 9-bit mode when enabled, else wake/data bit
  assign bit9      = (mode == `ASCS_MODE_A9 && parity_en) ? par_calc : tx_data[8]; // R08 R04

  // shift clock low first half of each bit, high second half
  assign sclk      = !(tx_busy && tx_sync && (tx_cnt <= `ASCS_TICK_MID)); // R05
  assign tx_line   = (tx_busy && !tx_sync) ? txsr[0] : 1'b1;
  // loopback routes the internal stream to the receiver
  assign rx_line   = loopback ? (tx_sync ? txsr[0] : tx_line) : rxd_in; // R07

  // transmitter
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      txsr    <= {`ASCS_FRAME_W{1'b1}};
      tx_cnt  <= 4'h0;
      tx_bits <= 4'h0;
      tx_sync <= 1'b0;
      tx_busy <= 1'b0;
      tx_irq  <= 1'b0;
    end
    else if (ce)
    begin
      tx_irq <= 1'b0;
      if (!tx_busy)
      begin
        if (tx_load)
        begin
          tx_busy <= 1'b1;
          tx_cnt  <= 4'h0;
          tx_sync <= sync_mode;
          if (sync_mode)
          begin
            txsr    <= {4'hf, tx_data[7:0]}; // R05 R06
            tx_bits <= `ASCS_BITS_SYNC;
          end
          else
          begin
            txsr    <= {2'h3, nine ? bit9 : 1'b1, tx_data[7:0], 1'b0}; // R03 R06
            tx_bits <= 4'h1 + `ASCS_BITS_DATA + {3'h0, nine} + 4'h1 + {3'h0, stop2}; // R03
          end
        end
      end
      else if (tick)
      begin
        tx_cnt <= tx_cnt + 4'h1;
        if (tx_cnt == `ASCS_TICK_LAST)
        begin
          txsr    <= {1'b1, txsr[`ASCS_FRAME_W-1:1]}; // R06
          tx_bits <= tx_bits - 4'h1;
          if (tx_bits == 4'h1)
          begin
            tx_busy <= 1'b0;
            tx_sync <= 1'b0;
            tx_irq  <= 1'b1; // R02
          end
        end
      end
    end
  end

  // pin drivers registered
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      txd_out <= 1'b1;
      rxd_out <= 1'b1;
      rxd_oe  <= 1'b0;
    end
    else if (ce)
    begin
      txd_out <= tx_sync ? sclk : tx_line; // R05
      rxd_out <= (tx_busy && tx_sync) ? txsr[0] : 1'b1;
      rxd_oe  <= tx_busy && tx_sync && !rcv_en;
    end
  end

  // receiver sequencing and error detection
  always @*
  begin
    next_err   = 3'h0;
    next_store = 1'b0;
    next_data  = rxsr;
    if (ce && tick)
    begin
      if (rx_state == `ASCS_RX_STOP && rx_cnt == `ASCS_TICK_LAST && !(rx_stop2 && rx_bits == 4'h0))
      begin
        next_data  = rx_nine ? rxsr : {1'b0, rxsr[8:1]};
        // wake-up mode drops data characters
        next_store = !(mode == `ASCS_MODE_WAKE && !next_data[8]); // R04
        next_err[`ASCS_ERR_FRM] = frame_chk_en && (frm_bad || !rx_line); // R09
        next_err[`ASCS_ERR_PAR] = parity_en && rx_nine && (mode == `ASCS_MODE_A9) &&
                                  ((^next_data[7:0] ^ parity_odd) != next_data[8]); // R08
      end
      else if (rx_state == `ASCS_RX_DATA && tx_sync && tx_cnt == `ASCS_TICK_MID &&
               tx_bits == 4'h1)
      begin
        next_data  = {1'b0, rx_line, rxsr[8:2]};
        next_store = 1'b1; // R05
      end
      next_err[`ASCS_ERR_OVR] = next_store && rx_full && !rx_read && ovr_chk_en; // R10
      if (!next_store)
        next_err = 3'h0;
    end
  end

  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      rx_state <= `ASCS_RX_IDLE;
      rx_cnt   <= 4'h0;
      rx_bits  <= 4'h0;
      rxsr     <= 9'h000;
      rx_nine  <= 1'b0;
      rx_stop2 <= 1'b0;
      frm_bad  <= 1'b0;
      rx_prev  <= 1'b1;
    end
    else if (ce)
    begin
      // start needs a falling edge, so a line held low cannot restart
      rx_prev <= rx_line;
      case (rx_state)
        `ASCS_RX_IDLE:
        begin
          rx_cnt  <= 4'h0;
          rx_bits <= 4'h0;
          frm_bad <= 1'b0;
          rx_nine <= nine;
          rx_stop2 <= stop2;
          if (rcv_en && sync_mode && tx_busy && tx_sync)
            rx_state <= `ASCS_RX_DATA;
          else if (rcv_en && !sync_mode && rx_prev && !rx_line) // R03
            rx_state <= `ASCS_RX_START;
        end
        `ASCS_RX_START:
        begin
          if (tick)
          begin
            rx_cnt <= rx_cnt + 4'h1;
            if (rx_cnt == `ASCS_TICK_MID)
            begin
              rx_cnt   <= 4'h0;
              rx_state <= rx_line ? `ASCS_RX_IDLE : `ASCS_RX_DATA; // R03
            end
          end
        end
        `ASCS_RX_DATA:
        begin
          if (tx_sync)
          begin
            // sample on rising shift clock edge
            if (tick && tx_cnt == `ASCS_TICK_MID)
            begin
              rxsr <= {rx_line, rxsr[8:1]}; // R06
              if (tx_bits == 4'h1)
                rx_state <= `ASCS_RX_IDLE;
            end
            if (!tx_busy)
              rx_state <= `ASCS_RX_IDLE;
          end
          else if (tick)
          begin
            rx_cnt <= rx_cnt + 4'h1;
            if (rx_cnt == `ASCS_TICK_LAST)
            begin
              rxsr    <= {rx_line, rxsr[8:1]}; // R06
              rx_bits <= rx_bits + 4'h1;
              if (rx_bits == `ASCS_BITS_DATA - {3'h0, !rx_nine})
              begin
                rx_bits  <= 4'h0;
                rx_state <= `ASCS_RX_STOP;
              end
            end
          end
        end
        `ASCS_RX_STOP:
        begin
          if (tick)
          begin
            rx_cnt <= rx_cnt + 4'h1;
            if (rx_cnt == `ASCS_TICK_LAST)
            begin
              if (rx_stop2 && rx_bits == 4'h0)
              begin
                rx_bits <= 4'h1;
                frm_bad <= !rx_line; // R09
              end
              else
                rx_state <= `ASCS_RX_IDLE;
            end
          end
        end
        default:
          rx_state <= `ASCS_RX_IDLE;
      endcase
    end
  end

  // receive buffer, sticky errors and request pulses
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      rx_data   <= 9'h000;
      rx_full   <= 1'b0;
      err_flags <= 3'h0;
      rx_irq    <= 1'b0;
      err_irq   <= 1'b0;
    end
    else if (ce)
    begin
      rx_irq  <= next_store; // R02
      err_irq <= |next_err; // R02 R13
      // a new event wins over a clear in the same cycle
      err_flags <= (err_flags & ~err_clr) | next_err; // R13
      if (next_store)
      begin
        rx_data <= next_data;
        rx_full <= 1'b1;
      end
      else if (rx_read)
        rx_full <= 1'b0;
    end
  end

endmodule
`default_nettype wire

//--- pkg/ascs_defs.vh
// constants for the asynchronous/synchronous serial channel
`ifndef ASCS_DEFS_VH
`define ASCS_DEFS_VH

// operating modes
`define ASCS_MODE_SYNC   2'h0
`define ASCS_MODE_A8     2'h1
`define ASCS_MODE_A9     2'h2
`define ASCS_MODE_WAKE   2'h3

// baud prescale dividers (select clear / set)
`define ASCS_PRE_DIV0    2'h2
`define ASCS_PRE_DIV1    2'h3

// sample ticks per bit and mid-bit point
`define ASCS_TICK_LAST   4'hf
`define ASCS_TICK_MID    4'h7

// frame shift register width and bit counts
`define ASCS_FRAME_W     12
`define ASCS_BITS_DATA   4'h8
`define ASCS_BITS_SYNC   4'h8

// receiver states
`define ASCS_RX_IDLE     2'h0
`define ASCS_RX_START    2'h1
`define ASCS_RX_DATA     2'h2
`define ASCS_RX_STOP     2'h3

// error flag positions
`define ASCS_ERR_PAR     0
`define ASCS_ERR_FRM     1
`define ASCS_ERR_OVR     2

`endif

//--- test/ascs_peer.sv
// far-side serial terminal: sends frames, collects characters
`default_nettype none
module ascs_peer #(
  parameter int BIT = 32
) (
  input  wire logic        clk,
  input  wire logic        txd,
  input  wire logic        send,
  input  wire logic [11:0] frame,
  input  wire logic [3:0]  nbits,
  output wire logic        rxd,
  output var  logic [7:0]  got
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] sh = 12'hfff;
  logic [3:0]  n = 4'h0;
  logic        p = 1'b1;
  int          c = 0;
  int          t = 0;
  // mark level between frames
  assign rxd = (n != 4'h0) ? sh[0] : 1'b1;
  always @(posedge clk)
  begin
    if (send)
    begin
      sh <= frame;
      n <= nbits;
      c <= BIT - 1;
    end
    else if (n != 4'h0)
    begin
      c <= (c == 0) ? BIT - 1 : c - 1;
      if (c == 0)
      begin
        sh <= {1'b1, sh[11:1]};
        n <= n - 4'h1;
      end
    end
  end
  // mid-bit sampling after a start edge
  always @(posedge clk)
  begin
    p <= txd;
    if (t == 0)
      t <= (p && !txd) ? 1 : 0;
    else
      t <= (t == 9 * BIT) ? 0 : t + 1;
    if (t > BIT && t % BIT == BIT / 2)
      got <= {txd, got[7:1]};
  end
endmodule
`default_nettype wire

//--- test/ascs_properties.sv
// port assertions for the serial channel
`default_nettype none
module ascs_properties #(
  parameter int RW = 16
) (
  input wire logic          clk,
  input wire logic          rst_b,
  input wire logic          ce,
  input wire logic [1:0]    mode,
  input wire logic          stop2,
  input wire logic          loopback,
  input wire logic          rcv_en,
  input wire logic          baud_prescale_select,
  input wire logic [RW-1:0] reload,
  input wire logic          tx_load,
  input wire logic [2:0]    err_clr,
  input wire logic          tx_busy,
  input wire logic          rx_full,
  input wire logic [2:0]    err_flags,
  input wire logic          tx_irq,
  input wire logic          rx_irq,
  input wire logic          err_irq,
  input wire logic          txd_out,
  input wire logic          rxd_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic plain;
  wire logic fast;
  wire logic slow;
  // one start, eight data, one stop at reload zero
  assign plain = mode == 2'h1 && !stop2 && reload == '0;
  assign fast = plain && !baud_prescale_select;
  assign slow = plain && baud_prescale_select;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_load_busy: assert property (tx_load && !tx_busy && ce |=> tx_busy)
    else $error("load not taken");
  a_start_bit: assert property ($rose(tx_busy) && mode != 2'h0 && !loopback |=> !txd_out)
    else $error("no start bit");
  a_done_pulse: assert property ($past(rst_b) && $fell(tx_busy) |-> tx_irq)
    else $error("no transmit request");
  a_rx_store: assert property (rx_irq |-> rx_full)
    else $error("receive request without data");
  a_err_flag: assert property (err_irq |-> err_flags != 3'h0)
    else $error("error request without flag");
  a_err_sticky: assert property ($past(rst_b) |->
      ((err_flags | $past(err_clr)) & $past(err_flags)) == $past(err_flags))
    else $error("error flag lost");
  a_frame_len: assert property ($rose(tx_busy) && fast |-> ##[316:324] $fell(tx_busy))
    else $error("frame length wrong");
  a_slow_len: assert property ($rose(tx_busy) && slow |-> ##[476:484] $fell(tx_busy))
    else $error("slow frame length wrong");
  a_oe_sync: assert property (rxd_oe |-> mode == 2'h0 && !rcv_en)
    else $error("data pin driven outside sync send");
endmodule

bind ascs_channel ascs_properties #(.RW(RW)) i_ascs_properties (.clk, .rst_b, .ce, .mode,
  .stop2, .loopback, .rcv_en, .baud_prescale_select, .reload, .tx_load, .err_clr, .tx_busy,
  .rx_full, .err_flags, .tx_irq, .rx_irq, .err_irq, .txd_out, .rxd_oe);
`default_nettype wire

//--- test/testbench.sv
// self-checking bench for the serial channel
`default_nettype none
`include "ascs_defs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst_b = 1'b0, ce = 1'b1, par_en = 1'b0, loopback = 1'b0;
  logic        rcv_en = 1'b1, sel = 1'b0, tx_load = 1'b0, rx_read = 1'b0, send = 1'b0;
  logic        st2 = 1'b0, odd = 1'b0;
  logic [1:0]  mode = 2'h1;
  logic [2:0]  err_clr = 3'h0;
  logic [8:0]  tx_data = 9'h000;
  logic [11:0] frame = 12'hfff;
  logic [3:0]  nbits = 4'ha;
  logic        tx_busy, rx_full, tx_irq, rx_irq, err_irq, txd_out, rxd_out, rxd_oe;
  logic [8:0]  rx_data;
  logic [2:0]  err_flags;
  logic [7:0]  got;
  wire logic   line_rx;
  wire logic   peer_rxd;
  int          fails = 0, samples_checked = 0;
  assign line_rx = rxd_oe ? rxd_out : peer_rxd;
  always #20 clk = ~clk;
  ascs_channel i_ascs_channel (.clk, .rst_b, .ce, .mode, .stop2(st2), .parity_en(par_en),
    .parity_odd(odd), .frame_chk_en(1'b1), .ovr_chk_en(1'b1), .loopback, .rcv_en,
    .baud_prescale_select(sel), .reload(16'h0000), .tx_data, .tx_load, .rx_read, .err_clr,
    .tx_busy, .rx_data, .rx_full, .err_flags, .tx_irq, .rx_irq, .err_irq, .txd_out,
    .rxd_in(line_rx), .rxd_out, .rxd_oe);
  ascs_peer i_ascs_peer (.clk, .txd(txd_out), .send, .frame, .nbits, .rxd(peer_rxd), .got);
  task automatic chk(input string nm, input logic [8:0] s, input logic [8:0] e);
    samples_checked++;
    if (s !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic rd_clr;
    @(negedge clk);
    rx_read = 1'b1;
    err_clr = 3'h7;
    @(negedge clk);
    rx_read = 1'b0;
    err_clr = 3'h0;
  endtask
  task automatic t_tx(input logic [7:0] d, input int len, input logic [3:0] nb);
    int n;
    @(negedge clk);
    tx_data = {1'b0, d};
    tx_load = 1'b1;
    @(negedge clk);
    tx_load = 1'b0;
    @(negedge clk);
    for (n = 1; n < 900 && tx_busy === 1'b1; n++)
      @(negedge clk);
    chk("tx_irq", 9'(tx_irq), 9'h001);
    chk("frame_bits", 9'((n + len / 2) / len), 9'(nb));
    if (len == 32 && !loopback)
      chk("line_byte", 9'(got), {1'b0, d});
  endtask
  task automatic t_rx(input logic [11:0] f, input logic [3:0] nb, input logic [7:0] d,
                      input logic [2:0] e, input logic irq, input logic rd);
    int i;
    @(negedge clk);
    frame = f;
    nbits = nb;
    send = 1'b1;
    @(negedge clk);
    send = 1'b0;
    for (i = 0; i < 500 && rx_irq !== 1'b1; i++)
      @(negedge clk);
    chk("rx_irq", 9'(rx_irq), 9'(irq));
    chk("err_irq", 9'(err_irq), 9'(irq && e != 3'h0));
    if (irq)
      chk("rx_data", 9'(rx_data[7:0]), 9'(d));
    chk("err_flags", 9'(err_flags), 9'(e));
    repeat (20) @(negedge clk);
    if (rd)
      rd_clr();
  endtask
  task automatic t_sync;
    logic [7:0] b;
    logic       pv;
    int         n;
    @(negedge clk);
    mode = 2'h0;
    rcv_en = 1'b0;
    tx_data = 9'h096;
    tx_load = 1'b1;
    @(negedge clk);
    tx_load = 1'b0;
    pv = 1'b1;
    for (n = 0; n < 400 && (n < 2 || tx_busy === 1'b1); n++)
    begin
      @(negedge clk);
      if (txd_out && !pv)
        b = {rxd_out, b[7:1]};
      pv = txd_out;
      if (n == 100)
      begin
        chk("rxd_oe", 9'(rxd_oe), 9'h001);
        // clock enable low holds the shift clock where it stands
        ce = 1'b0;
        repeat (40) @(negedge clk);
        chk("frozen_clk", 9'(txd_out), 9'(pv));
        ce = 1'b1;
      end
    end
    chk("sync_byte", 9'(b), 9'h096);
    @(negedge clk);
    mode = 2'h1;
    rcv_en = 1'b1;
  endtask
  task automatic t_sync_loop;
    int n;
    @(negedge clk);
    mode = 2'h0;
    loopback = 1'b1;
    tx_data = 9'h0c3;
    tx_load = 1'b1;
    @(negedge clk);
    tx_load = 1'b0;
    for (n = 0; n < 400 && rx_irq !== 1'b1; n++)
      @(negedge clk);
    chk("sync_irq", 9'(rx_irq), 9'h001);
    chk("sync_rx", rx_data, 9'h0c3);
    for (n = 0; n < 100 && tx_busy === 1'b1; n++)
      @(negedge clk);
    @(negedge clk);
    mode = 2'h1;
    loopback = 1'b0;
  endtask
  initial
  begin
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    chk("txd_out", 9'(txd_out), 9'h001);
    t_tx(8'ha5, 32, 4'ha);
    st2 = 1'b1;
    t_tx(8'h69, 32, 4'hb);
    st2 = 1'b0;
    sel = 1'b1;
    t_tx(8'h3c, 48, 4'ha);
    sel = 1'b0;
    t_rx(12'hf4a, 4'ha, 8'ha5, 3'h0, 1'b1, 1'b1);
    t_rx(12'h078, 4'ha, 8'h3c, 3'h1 << `ASCS_ERR_FRM, 1'b1, 1'b1);
    t_rx(12'he22, 4'ha, 8'h11, 3'h0, 1'b1, 1'b0);
    t_rx(12'he44, 4'ha, 8'h22, 3'h1 << `ASCS_ERR_OVR, 1'b1, 1'b1);
    mode = 2'h2;
    par_en = 1'b1;
    t_rx(12'hc02, 4'hb, 8'h01, 3'h1 << `ASCS_ERR_PAR, 1'b1, 1'b1);
    t_rx(12'he02, 4'hb, 8'h01, 3'h0, 1'b1, 1'b1);
    odd = 1'b1;
    t_rx(12'hc02, 4'hb, 8'h01, 3'h0, 1'b1, 1'b1);
    loopback = 1'b1;
    t_tx(8'h5a, 32, 4'hb);
    chk("loop_data", 9'(rx_data[7:0]), 9'h05a);
    chk("loop_err", 9'(err_flags), 9'h000);
    loopback = 1'b0;
    par_en = 1'b0;
    odd = 1'b0;
    rd_clr();
    mode = 2'h3;
    t_rx(12'hcaa, 4'hb, 8'h55, 3'h0, 1'b0, 1'b1);
    t_rx(12'hecc, 4'hb, 8'h66, 3'h0, 1'b1, 1'b1);
    mode = 2'h1;
    t_sync();
    t_sync_loop();
    summarize();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    summarize();
  end
endmodule
`default_nettype wire
